// *** shared/bafe_map.vh ***
`ifndef BAFE_MAP_VH
`define BAFE_MAP_VH

// ****************************************
// Register addresses
// ****************************************
`define BAFE_ADDR_IDENT 8'h00
`define BAFE_ADDR_FAULT 8'h01
`define BAFE_ADDR_BAL 8'h02
`define BAFE_ADDR_AOUT 8'h03
`define BAFE_ADDR_SW 8'h04
`define BAFE_ADDR_DSET 8'h05
`define BAFE_ADDR_CSET 8'h06
`define BAFE_ADDR_FSET 8'h07
`define BAFE_ADDR_WGATE 8'h08

// ****************************************
// Field positions and masks
// ****************************************
`define BAFE_SINGLE_BIT 5
`define BAFE_WAKE_BIT 4
`define BAFE_SLEEP_BIT 7
`define BAFE_LDMON_BIT 6
`define BAFE_CSW_BIT 1
`define BAFE_DSW_BIT 0
`define BAFE_DOC_AUTO_OFF_BIT 7
`define BAFE_SC_AUTO_OFF_BIT 4
`define BAFE_COC_AUTO_OFF_BIT 7
`define BAFE_CDIV_BIT 3
`define BAFE_DDIV_BIT 2
`define BAFE_WAKE_DIS_BIT 1
`define BAFE_WAKE_POL_BIT 0
`define BAFE_FSET_UNLOCK_BIT 7
`define BAFE_CSET_UNLOCK_BIT 6
`define BAFE_DSET_UNLOCK_BIT 5
`define BAFE_BAL_MASK 8'hfe
`define BAFE_AOUT_MASK 8'hcf
`define BAFE_SW_MASK 8'hc3
`define BAFE_SET_MASK 8'hdf
`define BAFE_WGATE_MASK 8'hf8

// ****************************************
// Reset values and delay dividers
// ****************************************
`define BAFE_RESET_VALUE 8'h00
`define BAFE_CDIV_SHIFT 5
`define BAFE_DDIV_SHIFT 6

`endif

// *** design/bafe_regs.v ***
`timescale 1ns/10ps
`include "bafe_map.vh"

module bafe_regs #(
  parameter DW = 8
) (
  sys_clk,
  reset,
  wr_stb,
  rd_stb,
  addr,
  wdata,
  rdata_q,
  wake_above_thresh,
  ext_overtemp,
  int_overtemp,
  load_fail,
  dis_short,
  dis_overcurrent,
  chg_overcurrent,
  fet_trip,
  balance_q,
  analog_sel_q,
  switch_ctrl_q,
  dset_q,
  cset_q,
  fset_q,
  wgate_q,
  charge_delay_shift_q,
  discharge_delay_shift_q
);
  input wire sys_clk;
  input wire reset;
  input wire wr_stb;
  input wire rd_stb;
  input wire [7:0] addr;
  input wire [DW-1:0] wdata;
  output reg [DW-1:0] rdata_q;
  input wire wake_above_thresh;
  input wire ext_overtemp;
  input wire int_overtemp;
  input wire load_fail;
  input wire dis_short;
  input wire dis_overcurrent;
  input wire chg_overcurrent;
  input wire fet_trip;
  output reg [DW-1:0] balance_q;
  output reg [DW-1:0] analog_sel_q;
  output reg [DW-1:0] switch_ctrl_q;
  output reg [DW-1:0] dset_q;
  output reg [DW-1:0] cset_q;
  output reg [DW-1:0] fset_q;
  output reg [DW-1:0] wgate_q;
  output reg [2:0] charge_delay_shift_q;
  output reg [2:0] discharge_delay_shift_q;

  // ****************************************
  // Register map overview
  // ****************************************
  // Address 00 is read only: bit 5 is tied high to mark a single front end.
  // Bit 4 of address 00 shows the wake pin state after the polarity setting.
  // Address 01 holds the latched fault flags in bits 5 to 0.
  // A read of address 01 clears each flag whose cause has already gone.
  // A cause that is still present keeps its flag high through the read.
  // Address 02 holds the cell balance switches in bits 7 to 1.
  // Address 03 holds two user flags and the four analog select bits.
  // Address 04 holds forced sleep, load monitor connect and two switch bits.
  // The switch bits read back the driver state held here, not a pin level.
  // Addresses 05 to 07 hold the protection and feature settings.
  // Each of those accepts a write only while its unlock bit is set.
  // Address 08 holds the three unlock bits and two more user flags.
  // Every other address reads as zero and ignores writes.
  // Reserved bits are masked on write, so they always read back as zero.
  // The block trusts the host to write zero there; the mask only keeps reads tidy.
  // Strobes may come in back-to-back cycles and each acts on its own edge.
  // Read data is registered: it is valid one cycle after the read strobe.
  // It then holds until the next read strobe; only a reset clears it sooner.
  // A write and a read strobe in one cycle are both honoured.
  // In that case the read returns the contents from before the write.
  // The fault read is also the clear, so a retried read loses the history.
  // The forced POR bit of the feature settings is only stored here.
  // Acting on it belongs to the analog side, which sees fset_q directly.

  // ****************************************
  // Live status and write decode
  // ****************************************
  wire wake_pol = fset_q[`BAFE_WAKE_POL_BIT];
  // Polarity picks which side of the threshold reads as awake.
  wire wake_state = wake_pol ? wake_above_thresh : ~wake_above_thresh;
  wire [5:0] cond_now = {ext_overtemp, int_overtemp, load_fail, dis_short, dis_overcurrent, chg_overcurrent};
  wire wr_bal = wr_stb && (addr == `BAFE_ADDR_BAL);
  wire wr_aout = wr_stb && (addr == `BAFE_ADDR_AOUT);
  wire wr_sw = wr_stb && (addr == `BAFE_ADDR_SW);
  wire wr_dset = wr_stb && (addr == `BAFE_ADDR_DSET) && wgate_q[`BAFE_DSET_UNLOCK_BIT];
  wire wr_cset = wr_stb && (addr == `BAFE_ADDR_CSET) && wgate_q[`BAFE_CSET_UNLOCK_BIT];
  wire wr_fset = wr_stb && (addr == `BAFE_ADDR_FSET) && wgate_q[`BAFE_FSET_UNLOCK_BIT];
  wire wr_wgate = wr_stb && (addr == `BAFE_ADDR_WGATE);
  wire rd_fault = rd_stb && (addr == `BAFE_ADDR_FAULT);
  // Auto shutdown applies while any one of the three auto-off bits is clear.
  wire auto_on = ~dset_q[`BAFE_DOC_AUTO_OFF_BIT] | ~dset_q[`BAFE_SC_AUTO_OFF_BIT]
    | ~cset_q[`BAFE_COC_AUTO_OFF_BIT];
  reg wake_state_q;
  reg [5:0] fault_q;
  wire wake_edge = wake_state & ~wake_state_q;
  wire [DW-1:0] ident_val = {2'b00, 1'b1, wake_state, 4'h0};
  // Hardware events that override the host's view of the switch register.
  wire trip_clear = fet_trip && auto_on;
  wire wake_clear = wake_edge && !fset_q[`BAFE_WAKE_DIS_BIT];
  reg [DW-1:0] switch_d;
  reg [DW-1:0] rdata_d;

  // ****************************************
  // Latched fault flags
  // ****************************************
  // A read clears a flag only if its cause is gone, so a set never loses to a clear.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_fault
      always @(posedge sys_clk) begin
        if (reset) begin
          fault_q[gi] <= 1'b0;
        end else if (cond_now[gi]) begin
          fault_q[gi] <= 1'b1;
        end else if (rd_fault) begin
          fault_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Host-only control registers
  // ****************************************
  // Cell balance switches; bit 0 is reserved and always reads zero.
  always @(posedge sys_clk) begin
    if (reset) begin
      balance_q <= `BAFE_RESET_VALUE;
    end else if (wr_bal) begin
      balance_q <= wdata & `BAFE_BAL_MASK;
    end
  end

  // Analog select and user flags; the two reserved bits are dropped.
  always @(posedge sys_clk) begin
    if (reset) begin
      analog_sel_q <= `BAFE_RESET_VALUE;
    end else if (wr_aout) begin
      analog_sel_q <= wdata & `BAFE_AOUT_MASK;
    end
  end

  // Unlock bits and user flags; this register itself is never locked.
  always @(posedge sys_clk) begin
    if (reset) begin
      wgate_q <= `BAFE_RESET_VALUE;
    end else if (wr_wgate) begin
      wgate_q <= wdata & `BAFE_WGATE_MASK;
    end
  end

  // ****************************************
  // Locked settings registers
  // ****************************************
  // Discharge settings; a write with the unlock bit clear is simply lost.
  always @(posedge sys_clk) begin
    if (reset) begin
      dset_q <= `BAFE_RESET_VALUE;
    end else if (wr_dset) begin
      dset_q <= wdata & `BAFE_SET_MASK;
    end
  end

  // Charge settings, including the two delay divider bits.
  always @(posedge sys_clk) begin
    if (reset) begin
      cset_q <= `BAFE_RESET_VALUE;
    end else if (wr_cset) begin
      cset_q <= wdata & `BAFE_SET_MASK;
    end
  end

  // Feature settings keep all eight bits, since none of them is reserved.
  always @(posedge sys_clk) begin
    if (reset) begin
      fset_q <= `BAFE_RESET_VALUE;
    end else if (wr_fset) begin
      fset_q <= wdata;
    end
  end

  // ****************************************
  // Switch drive and sleep
  // ****************************************
  // Wake state of the previous cycle, for the edge that ends forced sleep.
  // After reset it starts low, so an asserted wake state counts as an edge.
  always @(posedge sys_clk) begin
    if (reset) begin
      wake_state_q <= 1'b0;
    end else begin
      wake_state_q <= wake_state;
    end
  end

  // Host write first, then trip, then wake, so hardware events win a tie.
  always @* begin
    switch_d = switch_ctrl_q;
    if (wr_sw) begin
      switch_d = wdata & `BAFE_SW_MASK;
    end
    if (trip_clear) begin
      switch_d[`BAFE_CSW_BIT] = 1'b0;
      switch_d[`BAFE_DSW_BIT] = 1'b0;
    end
    if (wake_clear) begin
      switch_d[`BAFE_SLEEP_BIT] = 1'b0;
    end
  end

  // Reset leaves the switches off and forced sleep clear.
  always @(posedge sys_clk) begin
    if (reset) begin
      switch_ctrl_q <= `BAFE_RESET_VALUE;
    end else begin
      switch_ctrl_q <= switch_d;
    end
  end

  // ****************************************
  // Delay dividers
  // ****************************************
  // Shift counts let the charge delay counter divide by 32.
  always @(posedge sys_clk) begin
    if (reset) begin
      charge_delay_shift_q <= 3'd0;
    end else begin
      charge_delay_shift_q <= cset_q[`BAFE_CDIV_BIT] ? 3'd`BAFE_CDIV_SHIFT : 3'd0;
    end
  end

  // Shift counts let the discharge delay counter divide by 64.
  always @(posedge sys_clk) begin
    if (reset) begin
      discharge_delay_shift_q <= 3'd0;
    end else begin
      discharge_delay_shift_q <= cset_q[`BAFE_DDIV_BIT] ? 3'd`BAFE_DDIV_SHIFT : 3'd0;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // The fault read shows latch or live cause, so a flag is never missed.
  always @* begin
    rdata_d = `BAFE_RESET_VALUE;
    case (addr)
      `BAFE_ADDR_IDENT: rdata_d = ident_val;
      `BAFE_ADDR_FAULT: rdata_d = {2'b00, fault_q | cond_now};
      `BAFE_ADDR_BAL: rdata_d = balance_q;
      `BAFE_ADDR_AOUT: rdata_d = analog_sel_q;
      `BAFE_ADDR_SW: rdata_d = switch_ctrl_q;
      `BAFE_ADDR_DSET: rdata_d = dset_q;
      `BAFE_ADDR_CSET: rdata_d = cset_q;
      `BAFE_ADDR_FSET: rdata_d = fset_q;
      `BAFE_ADDR_WGATE: rdata_d = wgate_q;
      default: rdata_d = `BAFE_RESET_VALUE;
    endcase
  end

  // Read data is captured only on a read strobe and holds otherwise.
  always @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= `BAFE_RESET_VALUE;
    end else if (rd_stb) begin
      rdata_q <= rdata_d;
    end
  end
endmodule

// *** test/bafe_host.sv ***
`timescale 1ns/10ps
// Host model: one strobe per byte, launched on the falling edge, address and data scrambled when idle.
module bafe_host (
  input logic sys_clk,
  input logic [7:0] rdata_q,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr_stb = 0;
    rd_stb = 0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Callers pass bytes with reserved bits at zero and only addresses up to 08.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_stb = 1;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr_stb = 0;
    addr = ~a;
    wdata = ~d;
  endtask
  // Read data has landed by the falling edge after the strobe was taken.
  // Callers judge reserved bits of the returned byte themselves.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    rd_stb = 1;
    addr = a;
    @(negedge sys_clk);
    rd_stb = 0;
    addr = ~a;
    d = rdata_q;
  endtask
endmodule

// *** test/bafe_regs_assertions.sv ***
`timescale 1ns/10ps
// Checks the discharge settings lock, switch bits and delay dividers.
module bafe_regs_assertions (
  input logic sys_clk,
  input logic reset,
  input logic wr_stb,
  input logic rd_stb,
  input logic [7:0] addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata_q,
  input logic fet_trip,
  input logic [7:0] switch_ctrl_q,
  input logic [7:0] dset_q,
  input logic [7:0] cset_q,
  input logic [7:0] wgate_q,
  input logic [2:0] charge_delay_shift_q,
  input logic [2:0] discharge_delay_shift_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_dset_wr(bit g);
    wr_stb && addr == 8'h05 && wgate_q[5] == g;
  endsequence
  chk_dset_locked: assert property (s_dset_wr(0) |=> $stable(dset_q)) else $error("dset changed");
  chk_dset_open: assert property (s_dset_wr(1) |=> dset_q == ($past(wdata) & 8'hdf)) else $error("dset");
  chk_gate_write: assert property (wr_stb && addr == 8'h08 |=> wgate_q == ($past(wdata) & 8'hf8))
    else $error("wgate");
  chk_switch_write: assert property (wr_stb && addr == 8'h04 && !fet_trip |=>
    (switch_ctrl_q & 8'h03) == ($past(wdata) & 8'h03)) else $error("switch");
  chk_trip_clear: assert property (fet_trip && !(dset_q[7] && dset_q[4] && cset_q[7]) |=>
    (switch_ctrl_q & 8'h03) == 8'h00) else $error("trip");
  chk_sleep_zero: assert property (wr_stb && addr == 8'h04 && !wdata[7] |=> !switch_ctrl_q[7])
    else $error("sleep");
  chk_ident_bit: assert property (rd_stb && addr == 8'h00 |=> rdata_q[5]) else $error("ident");
  chk_cdiv_shift: assert property ($stable(cset_q) |-> charge_delay_shift_q == (cset_q[3] ? 3'h5 : 3'h0))
    else $error("cdiv");
  chk_ddiv_shift: assert property ($stable(cset_q) |-> discharge_delay_shift_q == (cset_q[2] ? 3'h6 : 3'h0))
    else $error("ddiv");
endmodule
bind bafe_regs bafe_regs_assertions chk (.*);

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic sys_clk = 0, reset = 1, wake_above_thresh = 0, fet_trip = 0, wr_stb, rd_stb;
  logic [5:0] cond = 0;
  logic [7:0] addr, wdata, rdata_q, d;
  logic [2:0] charge_delay_shift_q, discharge_delay_shift_q;
  int errors = 0, cmp_count = 0, cyc = 0, i;
  always #25 sys_clk = ~sys_clk;
  bafe_host host (.*);
  bafe_regs uut (.*, .ext_overtemp(cond[5]), .int_overtemp(cond[4]), .load_fail(cond[3]), .dis_short(cond[2]),
    .dis_overcurrent(cond[1]), .chg_overcurrent(cond[0]), .balance_q(), .analog_sel_q(), .switch_ctrl_q(),
    .dset_q(), .cset_q(), .fset_q(), .wgate_q());
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task conclude;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hung handshake is cut off long after the hundred or so cycles the tests need.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    reset = 0;
    rdc(8'h04, 8'h00);
    rdc(8'h00, 8'h30);
    wake_above_thresh = 1;
    rdc(8'h00, 8'h20);
    $display("test ident done");
    // Settings refuse writes until unlocked.
    host.wr(8'h05, 8'h9f);
    rdc(8'h05, 8'h00);
    host.wr(8'h08, 8'he0);
    host.wr(8'h05, 8'h9f);
    host.wr(8'h06, 8'h0c);
    rdc(8'h05, 8'h9f);
    chk("cdiv", 8'h05, {5'h00, charge_delay_shift_q});
    chk("ddiv", 8'h06, {5'h00, discharge_delay_shift_q});
    $display("test unlock done");
    // A fault stays latched after its cause ends, until read; a live one survives the read.
    for (i = 0; i < 6; i++) begin
      cond = 6'h01 << i;
      @(negedge sys_clk);
      cond = 6'h00;
      rdc(8'h01, 8'h01 << i);
      rdc(8'h01, 8'h00);
    end
    cond = 6'h01;
    rdc(8'h01, 8'h01);
    rdc(8'h01, 8'h01);
    cond = 6'h00;
    $display("test faults done");
    host.wr(8'h04, 8'h83);
    rdc(8'h04, 8'h83);
    host.wr(8'h04, 8'h03);
    rdc(8'h04, 8'h03);
    host.wr(8'h04, 8'h83);
    wake_above_thresh = 0;
    rdc(8'h04, 8'h03);
    fet_trip = 1;
    @(negedge sys_clk);
    fet_trip = 0;
    rdc(8'h04, 8'h00);
    $display("test switch done");
    host.wr(8'h02, 8'hfe);
    rdc(8'h02, 8'hfe);
    host.wr(8'h03, 8'hcf);
    rdc(8'h03, 8'hcf);
    host.wr(8'h07, 8'h01);
    rdc(8'h07, 8'h01);
    rdc(8'h00, 8'h20);
    wake_above_thresh = 1;
    rdc(8'h00, 8'h30);
    $display("test map done");
    conclude;
  end
endmodule
